// ### hdl/rxd_pkg.sv
// Constants, types and helpers for the receive delay and SRAM control bank.
// Assumes a 16-bit register view carried in the low half of a 32-bit APB bus.
// Summary of operation
// - Eight per-group fourteen-bit delay registers
// - Delay is startup guardband or operational delta
// - Guardband/delta registers reset to four cells
// - Unused upper register bits read zero
// - SRAM address from high and low registers
// - Three-bit field sizes external receive memory
// - Bits seven/six/five reset receiver/transmitter/counters
// - All three together give global reset
// - Eight max operational delay registers, reset zero
// - Select write starts readout register update
// - Type field picks link, min, max, history
// - Link from bits 3:0, group 2:0
// - Select bit six clears group history maximum
// - Readout is sign-extended eleven-bit cell count
// - Increment/decrement requests self-clear after adjustment
package rxd_pkg;

   // Geometry
   localparam int NGRP = 8;
   localparam int NLINK = 16;
   localparam int GRP_W = 3;
   localparam int LINK_W = 4;
   localparam int DLY_W = 14;
   localparam int MEAS_W = 11;
   localparam int REG_W = 16;
   localparam int IDX_W = 10;
   localparam int PADDR_W = 12;
   localparam int SADDR_HI_W = 4;
   localparam int SADDR_LO_W = 16;
   localparam int DSEL_W = 9;
   localparam int CTL_W = 9;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_INC = 10'h281;
   localparam logic [9:0] IDX_DEC = 10'h282;
   localparam logic [9:0] IDX_DLY_VAL = 10'h285;
   localparam logic [9:0] IDX_DLY_LINK = 10'h286;
   localparam logic [9:0] IDX_GB_BASE = 10'h287;
   localparam logic [9:0] IDX_SADDR_HI = 10'h297;
   localparam logic [9:0] IDX_SADDR_LO = 10'h298;
   localparam logic [9:0] IDX_SRAM_CTL = 10'h299;
   localparam logic [9:0] IDX_MOP_BASE = 10'h29A;
   localparam logic [9:0] IDX_DSEL = 10'h2AA;

   // Reset values
   localparam logic [13:0] GB_RST = 14'h0004;
   localparam logic [13:0] MOP_RST = 14'h0000;
   localparam logic [15:0] DLY_VAL_RST = 16'h0004;

   // Control register field positions
   localparam int CTL_MOPT = 8;
   localparam int CTL_RXRST = 7;
   localparam int CTL_TXRST = 6;
   localparam int CTL_CNTRST = 5;
   localparam int CTL_TST_HI = 4;
   localparam int CTL_TST_LO = 3;
   localparam int CTL_SIZE_HI = 2;
   localparam int CTL_SIZE_LO = 0;

   // Delay select field positions
   localparam int DSEL_MOTCLR = 6;
   localparam int DSEL_TYPE_HI = 5;
   localparam int DSEL_TYPE_LO = 4;
   localparam int DSEL_IDX_HI = 3;

   // Delay type codes, in field order 00..11
   typedef enum logic [1:0] {DT_LINK, DT_GMIN, DT_GMAX, DT_MOT} rxd_dly_type_t;

   // Bank size of external receive memory
   typedef enum logic [1:0] {BS_32K, BS_128K, BS_512K} rxd_bank_size_t;

   // Decoded memory configuration
   typedef struct packed {
      logic valid;
      logic two_banks;
      rxd_bank_size_t size;
   } rxd_sram_cfg_t;

   // One-cycle reset requests
   typedef struct packed {
      logic rx;
      logic tx;
      logic cnt;
      logic glob;
   } rxd_rst_req_t;

   // Measured delays from the recombiner, guardband already included
   typedef struct packed {
      logic [NLINK-1:0][MEAS_W-1:0] link_dly;
      logic [NGRP-1:0][MEAS_W-1:0] grp_min;
      logic [NGRP-1:0][MEAS_W-1:0] grp_max;
   } rxd_meas_t;

   // Size code decode
   function automatic rxd_sram_cfg_t rxd_size_dec(input logic [2:0] code);
      rxd_sram_cfg_t c;
      c.valid = ~(code[2] & code[1]);
      c.two_banks = code[0];
      c.size = code[2] ? BS_512K : (code[1] ? BS_128K : BS_32K);
      // 000/001 32K, 010/011 128K, 100/101 512K, 11x reserved
      return c;
   endfunction : rxd_size_dec

   // True when idx falls in an eight-register bank at base
   function automatic logic rxd_in_bank(input logic [9:0] idx, input logic [9:0] base);
      return (idx >= base) && (idx < base + 10'(NGRP));
   endfunction : rxd_in_bank

   // Group offset inside a bank
   function automatic logic [GRP_W-1:0] rxd_rel(input logic [9:0] idx,
                                               input logic [9:0] base);
      logic [9:0] d;
      d = idx - base;
      return d[GRP_W-1:0];
   endfunction : rxd_rel

   // Sign extension of an eleven-bit count to register width
   function automatic logic [REG_W-1:0] rxd_sext(input logic [MEAS_W-1:0] v);
      return {{(REG_W-MEAS_W){v[MEAS_W-1]}}, v};
   endfunction : rxd_sext

endpackage : rxd_pkg

// ### hdl/rxd_mem.sv
// Eight-word delay storage with one write port and two registered read ports.
// Assumes the caller gates writes and supplies the reset value.
`timescale 1ns/10ps
`default_nettype none
module rxd_mem #(
   parameter logic [13:0] RST_VAL = 14'h0000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic we,
   input wire logic [2:0] waddr,
   input wire logic [13:0] wdata,
   input wire logic [2:0] raddr_a,
   output logic [13:0] rdata_a,
   input wire logic [2:0] raddr_b,
   output logic [13:0] rdata_b
);
   logic [13:0] mem_q [rxd_pkg::NGRP]; // Storage words

   // Storage with reset value and soft clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < rxd_pkg::NGRP; i++) mem_q[i] <= RST_VAL;
      end else if (ce) begin
         for (int i = 0; i < rxd_pkg::NGRP; i++) begin
            if (clr) mem_q[i] <= RST_VAL;
            else if (we && waddr == 3'(i)) mem_q[i] <= wdata;
         end
      end
   end

   // Registered read ports
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_a <= RST_VAL;
         rdata_b <= RST_VAL;
      end else if (ce) begin
         rdata_a <= mem_q[raddr_a];
         rdata_b <= mem_q[raddr_b];
      end
   end
endmodule : rxd_mem
`default_nettype wire

// ### hdl/rxd_dly_track.sv
// Per-group maximum-over-time tracker and measured delay selector.
// Assumes measured values arrive as signed eleven-bit cell counts.
`timescale 1ns/10ps
`default_nettype none
module rxd_dly_track (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clr,
   input wire rxd_pkg::rxd_meas_t meas,
   input wire logic hist_clr,
   input wire logic [2:0] hist_grp,
   input wire rxd_pkg::rxd_dly_type_t sel_type,
   input wire logic [3:0] sel_idx,
   output logic [10:0] pick
);
   logic [10:0] hist_q [rxd_pkg::NGRP]; // Maximum seen per group
   wire [2:0] sel_grp = sel_idx[2:0]; // Group index for group types

   // History update; a history clear reloads the live value so no sample is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int g = 0; g < rxd_pkg::NGRP; g++) hist_q[g] <= '0;
      end else if (ce) begin
         for (int g = 0; g < rxd_pkg::NGRP; g++) begin
            if (clr) hist_q[g] <= '0;
            else if (hist_clr && hist_grp == 3'(g)) hist_q[g] <= meas.grp_max[g];
            else if ($signed(meas.grp_max[g]) > $signed(hist_q[g])) hist_q[g] <= meas.grp_max[g];
         end
      end
   end

   // Source selection by delay type
   always_comb begin
      unique case (sel_type)
         rxd_pkg::DT_LINK: pick = meas.link_dly[sel_idx];
         rxd_pkg::DT_GMIN: pick = meas.grp_min[sel_grp];
         rxd_pkg::DT_GMAX: pick = meas.grp_max[sel_grp];
         rxd_pkg::DT_MOT: pick = hist_q[sel_grp];
      endcase
   end
endmodule : rxd_dly_track
`default_nettype wire

// ### hdl/rxd_regs.sv
// APB register bank for receive delay control and external SRAM control.
// Assumes a single clock, an APB master, and a recombiner that consumes
// guardband/delta lookups and acknowledges increment and decrement requests.
`timescale 1ns/10ps
`default_nettype none
module rxd_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Recombiner side
   input wire rxd_pkg::rxd_meas_t meas,
   input wire logic [2:0] gb_idx,
   output logic [13:0] gb_val,
   input wire logic [2:0] mop_idx,
   output logic [13:0] mop_val,
   input wire logic [7:0] inc_done,
   input wire logic [7:0] dec_done,
   output logic [7:0] inc_req,
   output logic [7:0] dec_req,
   // SRAM and reset control
   output logic [19:0] sram_addr,
   output rxd_pkg::rxd_sram_cfg_t sram_cfg,
   output logic mem_opt,
   output logic [1:0] test_mode,
   output rxd_pkg::rxd_rst_req_t rst_req
);

   // Bus state
   // Answer is registered, so pready never
   // depends combinationally on the request.
   // Costs one wait state on every transfer.
   logic pready_q; // Second access cycle marker
   logic [31:0] prdata_q; // Captured read word
   logic pslverr_q; // Captured error flag

   // Register state
   // Only bits that the map defines are kept;
   // reserved bits are rebuilt as zeros on reads.
   // Reset bits 7:5 are not stored at all.
   logic [3:0] saddr_hi_q; // SRAM address bits 19:16
   logic [15:0] saddr_lo_q; // SRAM address bits 15:0
   logic mopt_q; // Memory optimisation
   logic [1:0] tst_q; // Test bits, zero for normal use
   logic [2:0] size_q; // Memory size code
   logic [8:0] dsel_q; // Delay select register image
   logic [15:0] dly_val_q; // Readable delay value
   logic [3:0] dly_link_q; // Link number for readout
   logic upd_q; // Readout update pending
   logic [7:0] inc_q; // Increment requests
   logic [7:0] dec_q; // Decrement requests
   rxd_pkg::rxd_rst_req_t rst_q; // Reset request pulses

   // Address decode
   // Word index from the byte address; the two
   // eight-word banks are range checked, the
   // rest are single words.
   // Anything unmapped or misaligned is an error.
   wire [9:0] idx = paddr[11:2]; // Word index
   wire hit_gb = rxd_pkg::rxd_in_bank(idx, rxd_pkg::IDX_GB_BASE); // Guardband bank
   wire hit_mop = rxd_pkg::rxd_in_bank(idx, rxd_pkg::IDX_MOP_BASE); // Max op bank
   wire [2:0] gb_rel = rxd_pkg::rxd_rel(idx, rxd_pkg::IDX_GB_BASE); // Offset in bank
   wire [2:0] mop_rel = rxd_pkg::rxd_rel(idx, rxd_pkg::IDX_MOP_BASE); // Offset in bank
   wire hit_inc = idx == rxd_pkg::IDX_INC; // Increment request
   wire hit_dec = idx == rxd_pkg::IDX_DEC; // Decrement request
   wire hit_dval = idx == rxd_pkg::IDX_DLY_VAL; // Delay readout
   wire hit_dlnk = idx == rxd_pkg::IDX_DLY_LINK; // Link readout
   wire hit_shi = idx == rxd_pkg::IDX_SADDR_HI; // Address high
   wire hit_slo = idx == rxd_pkg::IDX_SADDR_LO; // Address low
   wire hit_ctl = idx == rxd_pkg::IDX_SRAM_CTL; // SRAM control
   wire hit_dsel = idx == rxd_pkg::IDX_DSEL; // Delay select
   wire hit_any = hit_gb | hit_mop | hit_inc | hit_dec | hit_dval | hit_dlnk
                | hit_shi | hit_slo | hit_ctl | hit_dsel; // Mapped address
   wire misalign = paddr[1:0] != 2'b00; // Not word aligned
   wire bad = ~hit_any | misalign; // Error answer

   // Transfer qualifiers
   // Writes act only on the completing edge, so
   // a refused or still waiting request never
   // disturbs a register.
   wire acc = psel & penable; // Access phase
   wire fin = acc & pready_q; // Completing edge
   wire wr = fin & pwrite & ~bad; // Write takes effect
   wire glob = rst_q.glob; // Global soft reset active
   wire [15:0] wd = pwdata[15:0]; // Register-width write data

   // Per-register write strobes
   wire wr_gb = wr & hit_gb; // Guardband word
   wire wr_mop = wr & hit_mop; // Max op word
   wire wr_inc = wr & hit_inc; // Increment word
   wire wr_dec = wr & hit_dec; // Decrement word
   wire wr_shi = wr & hit_shi; // Address high
   wire wr_slo = wr & hit_slo; // Address low
   wire wr_ctl = wr & hit_ctl; // Control word
   wire wr_dsel = wr & hit_dsel; // Delay select word

   // Reset bits written in this control write
   wire w_rx = wr_ctl & wd[rxd_pkg::CTL_RXRST]; // Receiver reset
   wire w_tx = wr_ctl & wd[rxd_pkg::CTL_TXRST]; // Transmitter reset
   wire w_cnt = wr_ctl & wd[rxd_pkg::CTL_CNTRST]; // Counter reset
   wire w_glob = w_rx & w_tx & w_cnt; // All three at once

   // Delay storage banks
   // Port a serves the bus, port b the lookup.
   // Both are registered, so a bus read sets its
   // address one edge before the capture edge.
   // Both banks share one storage module.
   logic [13:0] gb_rd; // Guardband bus read word
   logic [13:0] mop_rd; // Max op bus read word

   // Guardband or delta per group
   rxd_mem #(
      .RST_VAL(rxd_pkg::GB_RST)
   ) u_gb (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .clr(glob),
      .we(wr_gb),
      .waddr(gb_rel),
      .wdata(wd[13:0]),
      .raddr_a(gb_rel),
      .rdata_a(gb_rd),
      .raddr_b(gb_idx),
      .rdata_b(gb_val)
   );

   // Maximum operational delay per group
   rxd_mem #(
      .RST_VAL(rxd_pkg::MOP_RST)
   ) u_mop (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .clr(glob),
      .we(wr_mop),
      .waddr(mop_rel),
      .wdata(wd[13:0]),
      .raddr_a(mop_rel),
      .rdata_a(mop_rd),
      .raddr_b(mop_idx),
      .rdata_b(mop_val)
   );

   // Measured delay selection
   // Select image drives the picker directly;
   // the readout copy waits one edge so the new
   // type and index have settled.
   // History clear reloads the live group value.
   wire rxd_pkg::rxd_dly_type_t dtype =
      rxd_pkg::rxd_dly_type_t'(dsel_q[rxd_pkg::DSEL_TYPE_HI:rxd_pkg::DSEL_TYPE_LO]);
   wire [3:0] didx = dsel_q[rxd_pkg::DSEL_IDX_HI:0]; // Link or group index
   wire hist_clr = wr_dsel & wd[rxd_pkg::DSEL_MOTCLR]; // History clear request
   logic [10:0] pick; // Selected measured delay

   // History tracker and selector
   rxd_dly_track u_trk (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .clr(glob),
      .meas(meas),
      .hist_clr(hist_clr),
      .hist_grp(wd[2:0]),
      .sel_type(dtype),
      .sel_idx(didx),
      .pick(pick)
   );

   // Link number shown with the readout
   wire [3:0] link_of = (dtype == rxd_pkg::DT_LINK) ? didx : {1'b0, didx[2:0]};

   // Read mux; unused upper bits are zero
   // Priority order is harmless: the hits are
   // mutually exclusive by construction.
   // Write-only reset bits read back as zero.
   wire [15:0] rd16 =
      hit_gb ? {2'b00, gb_rd} :
      hit_mop ? {2'b00, mop_rd} :
      hit_inc ? {8'h00, inc_q} :
      hit_dec ? {8'h00, dec_q} :
      hit_dval ? dly_val_q :
      hit_dlnk ? {12'h000, dly_link_q} :
      hit_shi ? {12'h000, saddr_hi_q} :
      hit_slo ? saddr_lo_q :
      hit_ctl ? {7'h00, mopt_q, 3'b000, tst_q, size_q} :
      hit_dsel ? {7'h00, dsel_q} :
      16'h0000;

   // APB handshake: one wait state, registered answer
   // First access edge captures data and error,
   // the second edge completes the transfer.
   // A low clock enable also stretches the wait.
   // Outputs are the flops themselves.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         // First access cycle captures, second completes
         if (acc && !pready_q) begin
            pready_q <= 1'b1;
            prdata_q <= (pwrite || bad) ? 32'h0000_0000 : {16'h0000, rd16};
            pslverr_q <= bad;
         end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // Answer outputs
   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // SRAM test-access address
   // Both halves are plain storage; the transfer
   // engine outside samples the joined address.
   // Software must load it before a transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saddr_hi_q <= 4'h0;
         saddr_lo_q <= 16'h0000;
      end else if (ce) begin
         if (glob) begin
            saddr_hi_q <= 4'h0;
            saddr_lo_q <= 16'h0000;
         end else begin
            if (wr_shi) saddr_hi_q <= wd[3:0];
            if (wr_slo) saddr_lo_q <= wd;
         end
      end
   end

   // Full address; software loads it before a transfer
   assign sram_addr = {saddr_hi_q, saddr_lo_q};

   // SRAM control: stored fields
   // Size, optimisation and test bits are kept.
   // Bit 8 is not checked against bit 0; that
   // pairing is left to software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mopt_q <= 1'b0;
         tst_q <= 2'b00;
         size_q <= 3'b000;
      end else if (ce) begin
         if (glob) begin
            mopt_q <= 1'b0;
            tst_q <= 2'b00;
            size_q <= 3'b000;
         end else if (wr_ctl) begin
            mopt_q <= wd[rxd_pkg::CTL_MOPT];
            tst_q <= wd[rxd_pkg::CTL_TST_HI:rxd_pkg::CTL_TST_LO];
            size_q <= wd[rxd_pkg::CTL_SIZE_HI:rxd_pkg::CTL_SIZE_LO];
         end
      end
   end

   // Decoded configuration
   assign sram_cfg = rxd_pkg::rxd_size_dec(size_q);
   assign mem_opt = mopt_q;
   assign test_mode = tst_q;

   // Reset request pulses; writing zero does nothing
   // One pulse per write, in the cycle after the
   // completing edge. Global reset needs all
   // three bits in the same write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_q <= '0;
      end else if (ce) begin
         rst_q.rx <= w_rx;
         rst_q.tx <= w_tx;
         rst_q.cnt <= w_cnt;
         rst_q.glob <= w_glob;
      end
   end

   // Pulse outputs
   assign rst_req = rst_q;

   // Delay select and readout update
   // A new select write restarts the update, so
   // back-to-back selects show the last one.
   // Global reset returns the readout to four.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsel_q <= 9'h000;
         upd_q <= 1'b0;
         dly_val_q <= rxd_pkg::DLY_VAL_RST;
         dly_link_q <= 4'h0;
      end else if (ce) begin
         if (glob) begin
            dsel_q <= 9'h000;
            upd_q <= 1'b0;
            dly_val_q <= rxd_pkg::DLY_VAL_RST;
            dly_link_q <= 4'h0;
         end else begin
            // Select write arms an update one cycle later
            if (wr_dsel) dsel_q <= wd[8:0];
            upd_q <= wr_dsel;
            if (upd_q) begin
               dly_val_q <= rxd_pkg::rxd_sext(pick);
               dly_link_q <= link_of;
            end
         end
      end
   end

   // Increment and decrement requests
   // Ones are OR-ed in, zeros do nothing; each
   // bit drops on its own acknowledge, unless
   // set again in that same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inc_q <= 8'h00;
         dec_q <= 8'h00;
      end else if (ce) begin
         if (glob) begin
            inc_q <= 8'h00;
            dec_q <= 8'h00;
         end else begin
            // Software set wins over a same-cycle completion
            inc_q <= (inc_q & ~inc_done) | (wr_inc ? wd[7:0] : 8'h00);
            dec_q <= (dec_q & ~dec_done) | (wr_dec ? wd[7:0] : 8'h00);
         end
      end
   end

   // Request outputs to the recombiner
   assign inc_req = inc_q;
   assign dec_req = dec_q;

endmodule : rxd_regs
`default_nettype wire

// ### sim/rxd_regs_asserts.sv
// Port checker for the receive delay and SRAM control bank.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/10ps
`default_nettype none
module rxd_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] inc_done,
   input wire logic [7:0] inc_req,
   input wire logic [19:0] sram_addr,
   input wire rxd_pkg::rxd_rst_req_t rst_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Handshake: one wait state, one-cycle ready
   chk_wait_state: assert property (psel && !penable |=> !pready) else $error("early ready");
   chk_ready_due: assert property (psel && penable && !pready |=> pready) else $error("no ready");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   chk_upper_zero: assert property (prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read not zero");
   chk_rx_pulse: assert property (rst_req.rx |=> !rst_req.rx)
      else $error("receiver reset too long");
   chk_rx_cause: assert property ($rose(rst_req.rx) |-> $past(pready && pwrite
      && paddr == 12'hA64 && pwdata[7])) else $error("receiver reset uncaused");
   chk_glob_all: assert property (rst_req.glob |-> rst_req.rx && rst_req.tx
      && rst_req.cnt) else $error("global reset incomplete");
   chk_inc_clear: assert property (ce && inc_req[0] && inc_done[0] && !pready
      |=> !inc_req[0]) else $error("increment not cleared");
   chk_addr_cause: assert property ($changed(sram_addr) |-> $past(pready && pwrite)
      || $past(rst_req.glob)) else $error("address changed alone");
   // Main scenarios seen
   cover property (pready && pslverr);
   cover property (rst_req.glob);
   cover property ($fell(inc_req[0]));
endmodule : rxd_asserts
bind rxd_regs rxd_asserts u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .inc_done, .inc_req, .sram_addr, .rst_req);
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the receive delay and SRAM control bank.
// Assumes the bank answers APB with pready; clock enable dropped once.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, mem_opt, er;
   rxd_pkg::rxd_meas_t meas = '0;
   logic [2:0] gb_idx = 3'h3;
   logic [13:0] gb_val, mop_val;
   logic [7:0] inc_done = 8'h00, dec_done = 8'h00, inc_req, dec_req;
   logic [19:0] sram_addr;
   rxd_pkg::rxd_sram_cfg_t sram_cfg;
   logic [1:0] test_mode;
   rxd_pkg::rxd_rst_req_t rst_req;
   int n_mismatch = 0, check_count = 0;
   // 50 ns clock
   always #25 pclk = ~pclk;
   rxd_regs uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .meas, .gb_idx, .gb_val, .mop_idx(gb_idx), .mop_val,
      .inc_done, .dec_done, .inc_req, .dec_req, .sram_addr, .sram_cfg, .mem_opt,
      .test_mode, .rst_req);
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task give_verdict();
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // One APB transfer; holds until pready
   task apb(input logic w, input logic [9:0] i, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         n_mismatch++;
         give_verdict();
      end
   endtask : apb
   task rdc(input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, i, 16'h0000);
      chk("prdata", rd, e);
   endtask : rdc
   task t_reset();
      for (int g = 0; g < 8; g++) begin
         rdc(rxd_pkg::IDX_GB_BASE + 10'(g), 32'h0000_0004);
         rdc(rxd_pkg::IDX_MOP_BASE + 10'(g), 32'h0000_0000);
      end
      rdc(rxd_pkg::IDX_DLY_VAL, 32'h0000_0004);
   endtask : t_reset
   task t_store();
      for (int g = 0; g < 8; g++) begin
         apb(1'b1, rxd_pkg::IDX_GB_BASE + 10'(g), 16'hFFF0 + 16'(g));
         apb(1'b1, rxd_pkg::IDX_MOP_BASE + 10'(g), 16'hFFF8 + 16'(g));
      end
      for (int g = 0; g < 8; g++) begin
         rdc(rxd_pkg::IDX_GB_BASE + 10'(g), 32'h0000_3FF0 + 32'(g));
         rdc(rxd_pkg::IDX_MOP_BASE + 10'(g), 32'h0000_3FF8 + 32'(g));
      end
      chk("gb_val", 32'(gb_val), 32'h0000_3FF3);
      chk("mop_val", 32'(mop_val), 32'h0000_3FFB);
   endtask : t_store
   task t_sram();
      apb(1'b1, rxd_pkg::IDX_SADDR_HI, 16'hFFFF);
      apb(1'b1, rxd_pkg::IDX_SADDR_LO, 16'h1234);
      @(posedge pclk);
      chk("sram_addr", 32'(sram_addr), 32'h000F_1234);
      rdc(rxd_pkg::IDX_SADDR_HI, 32'h0000_000F);
      rdc(10'h2A2, 32'h0000_0000);
      chk("pslverr", 32'(er), 32'h0000_0001);
   endtask : t_sram
   task t_size();
      logic [2:0] c;
      logic [31:0] cfg_tab;
      // Expected {valid, two_banks, size} per code, code 0 in the low nibble
      cfg_tab = 32'h62EA_D9C8;
      for (int k = 0; k < 8; k++) begin
         c = k[2:0];
         apb(1'b1, rxd_pkg::IDX_SRAM_CTL, 16'(c));
         @(posedge pclk);
         chk("sram_cfg", 32'(sram_cfg), 32'(cfg_tab[4*k +: 4]));
      end
   endtask : t_size
   task t_ctl();
      apb(1'b1, rxd_pkg::IDX_SRAM_CTL, 16'h0181);
      @(posedge pclk);
      chk("rst_req", 32'(rst_req), 32'h0000_0008);
      chk("mem_opt test_mode", 32'({mem_opt, test_mode}), 32'h0000_0004);
      rdc(rxd_pkg::IDX_SRAM_CTL, 32'h0000_0101);
      apb(1'b1, rxd_pkg::IDX_SRAM_CTL, 16'h0000);
   endtask : t_ctl
   task sel(input logic [15:0] d, input logic [31:0] v, input logic [31:0] lk);
      apb(1'b1, rxd_pkg::IDX_DSEL, d);
      rdc(rxd_pkg::IDX_DLY_VAL, v);
      rdc(rxd_pkg::IDX_DLY_LINK, lk);
   endtask : sel
   task t_dsel();
      sel(16'h0005, 32'h0000_FFF0, 32'h0000_0005);
      sel(16'h000D, 32'h0000_0123, 32'h0000_000D);
      sel(16'h0012, 32'h0000_0005, 32'h0000_0002);
      sel(16'h002A, 32'h0000_0023, 32'h0000_0002);
      meas.grp_max[2] <= 11'h010;
      sel(16'h0032, 32'h0000_0023, 32'h0000_0002);
      sel(16'h0072, 32'h0000_0010, 32'h0000_0002);
   endtask : t_dsel
   task t_incdec();
      apb(1'b1, rxd_pkg::IDX_INC, 16'h0081);
      apb(1'b1, rxd_pkg::IDX_DEC, 16'h0002);
      @(posedge pclk);
      chk("inc_req", 32'(inc_req), 32'h0000_0081);
      chk("dec_req", 32'(dec_req), 32'h0000_0002);
      ce <= 1'b0;
      inc_done <= 8'h01;
      dec_done <= 8'h02;
      @(posedge pclk);
      ce <= 1'b1;
      @(posedge pclk);
      chk("inc_req frozen", 32'(inc_req), 32'h0000_0081);
      inc_done <= 8'h00;
      dec_done <= 8'h00;
      @(posedge pclk);
      chk("inc_req", 32'(inc_req), 32'h0000_0080);
      chk("dec_req", 32'(dec_req), 32'h0000_0000);
   endtask : t_incdec
   task t_glob();
      apb(1'b1, rxd_pkg::IDX_GB_BASE, 16'h0055);
      apb(1'b1, rxd_pkg::IDX_SRAM_CTL, 16'h00E0);
      @(posedge pclk);
      chk("rst_req", 32'(rst_req), 32'h0000_000F);
      rdc(rxd_pkg::IDX_GB_BASE, 32'h0000_0004);
      chk("sram_addr", 32'(sram_addr), 32'h0000_0000);
   endtask : t_glob
   // Main sequence
   initial begin
      meas.link_dly[5] = 11'h7F0;
      meas.link_dly[13] = 11'h123;
      meas.grp_min[2] = 11'h005;
      meas.grp_max[2] = 11'h023;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_store();
      t_sram();
      t_size();
      t_ctl();
      t_dsel();
      t_incdec();
      t_glob();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
